// *** shared/rbt_consts.svh ***
`ifndef RBT_CONSTS_SVH
`define RBT_CONSTS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define RBT_DW       8
`define RBT_BUS_DW   32
`define RBT_AW       8
`define RBT_CNT_W    16

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RBT_OFS_CTRL    8'h00
`define RBT_OFS_CAPTURE 8'h04
`define RBT_OFS_STORE   8'h08
`define RBT_OFS_PORTS   8'h0C
`define RBT_OFS_STATUS  8'h10
`define RBT_OFS_COUNT   8'h14

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RBT_CTRL_W     4
`define RBT_CTRL_RST   4'h1
`define RBT_BIT_A      0
`define RBT_BIT_B      1
`define RBT_CNT_ONE    16'h0001
`define RBT_RD_ZERO    32'h0000_0000

`endif

// *** shared/rbt_pkg.sv ***
`include "rbt_consts.svh"

package rbt_pkg;

  typedef logic [`RBT_DW-1:0] rbt_byte_t;

  typedef enum logic [1:0] {
    RBT_ISOLATE,
    RBT_DRIVE_B,
    RBT_DRIVE_A
  } rbt_mode_e;

  // Bit 0 is the active-low port enable
  typedef struct packed {
    logic b_to_a_source_select;
    logic a_to_b_source_select;
    logic dir;
    logic oe_n;
  } rbt_ctrl_s;

  typedef struct packed {
    rbt_byte_t [1:0] q;
  } rbt_store_s;

  typedef struct packed {
    rbt_ctrl_s               ctrl;
    logic                    cab_prev;
    logic                    cba_prev;
    logic                    new_a;
    logic                    new_b;
    logic [`RBT_CNT_W-1:0]   cnt_a;
    logic [`RBT_CNT_W-1:0]   cnt_b;
    logic [`RBT_BUS_DW-1:0]  rdata;
    rbt_byte_t               a_out;
    logic                    a_oe_n;
    rbt_byte_t               b_out;
    logic                    b_oe_n;
  } rbt_top_s;

endpackage

// *** shared/rbt_store_if.sv ***
`timescale 1ns/1ps

interface rbt_store_if;
  logic             [1:0] load;
  rbt_pkg::rbt_byte_t [1:0] din;
  rbt_pkg::rbt_byte_t [1:0] q;

  modport store (input load, input din, output q);
  modport user  (output load, output din, input q);
endinterface

// *** src/rbt_store.sv ***
`timescale 1ns/1ps
`include "rbt_consts.svh"

module rbt_store (
  input wire logic   core_clk,
  input wire logic   reset_n,
  rbt_store_if.store sif
);

  // ----------------------------------------------------------------
  // Two capture registers, index 0 holds A, index 1 holds B
  // ----------------------------------------------------------------
  rbt_pkg::rbt_store_s st_q;
  rbt_pkg::rbt_store_s st_d;

  always_comb begin
    st_d = st_q;
    for (int i = 0; i < 2; i++) begin
      if (sif.load[i]) begin
        st_d.q[i] = sif.din[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_out
      assign sif.q[g] = st_q.q[g];
    end
  endgenerate

endmodule

// *** src/rbt_top.sv ***
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "rbt_consts.svh"

module rbt_top (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic [`RBT_AW-1:0]      reg_addr,
  input  wire logic [`RBT_BUS_DW-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`RBT_BUS_DW-1:0]  reg_rdata,
  input  wire logic                    a_side_capture_clock,
  input  wire logic                    b_side_capture_clock,
  input  wire logic [`RBT_DW-1:0]      a_in,
  output logic      [`RBT_DW-1:0]      a_out,
  output logic                         a_oe_n,
  input  wire logic [`RBT_DW-1:0]      b_in,
  output logic      [`RBT_DW-1:0]      b_out,
  output logic                         b_oe_n
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic rbt_hit(
    input logic [`RBT_AW-1:0] addr,
    input logic [`RBT_AW-1:0] ofs
  );
    rbt_hit = (addr == ofs);
  endfunction

  function automatic rbt_pkg::rbt_mode_e rbt_mode(
    input rbt_pkg::rbt_ctrl_s c
  );
    if (c.oe_n) begin
      rbt_mode = rbt_pkg::RBT_ISOLATE;
    end else if (c.dir) begin
      rbt_mode = rbt_pkg::RBT_DRIVE_B;
    end else begin
      rbt_mode = rbt_pkg::RBT_DRIVE_A;
    end
  endfunction

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  rbt_pkg::rbt_top_s   st_q;
  rbt_pkg::rbt_top_s   st_d;
  rbt_pkg::rbt_mode_e  mode;
  rbt_pkg::rbt_byte_t  a_next;
  rbt_pkg::rbt_byte_t  b_next;
  logic                cap_a;
  logic                cap_b;
  logic                sw_cap_a;
  logic                sw_cap_b;

  rbt_store_if sif ();

  rbt_store u_store (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .sif      (sif)
  );

  // ----------------------------------------------------------------
  // Capture events
  // ----------------------------------------------------------------
  // The capture pins are sampled on core_clk; a rising edge is seen
  // as a low-to-high change between two samples. Pulses shorter than
  // one core_clk period may be missed, a limit of sampling the pins.
  always_comb begin
    sw_cap_a = reg_wr && rbt_hit(reg_addr, `RBT_OFS_CAPTURE)
               && reg_wdata[`RBT_BIT_A];
    sw_cap_b = reg_wr && rbt_hit(reg_addr, `RBT_OFS_CAPTURE)
               && reg_wdata[`RBT_BIT_B];
    // No term of the enable, direction or selects enters here
    cap_a = (a_side_capture_clock && !st_q.cab_prev) || sw_cap_a;
    cap_b = (b_side_capture_clock && !st_q.cba_prev) || sw_cap_b;
  end

  // Each register has its own load, so one or both may load in a
  // cycle whatever the mode
  always_comb begin
    sif.load[`RBT_BIT_A] = cap_a;
    sif.load[`RBT_BIT_B] = cap_b;
    // Port value as seen on the wire; when we drive a port the outside
    // leaves it alone, so the wire then carries our own data
    sif.din[`RBT_BIT_A]  = a_in;
    sif.din[`RBT_BIT_B]  = b_in;
  end

  // Value each register holds after this edge, so a stored-source
  // output moves in the same cycle as the register itself
  always_comb begin
    a_next = cap_a ? a_in : sif.q[`RBT_BIT_A];
    b_next = cap_b ? b_in : sif.q[`RBT_BIT_B];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d          = st_q;
    st_d.cab_prev = a_side_capture_clock;
    st_d.cba_prev = b_side_capture_clock;

    // Control register
    if (reg_wr && rbt_hit(reg_addr, `RBT_OFS_CTRL)) begin
      st_d.ctrl = rbt_pkg::rbt_ctrl_s'(reg_wdata[`RBT_CTRL_W-1:0]);
    end
    // Port drive follows the control value taking effect this edge;
    // a STATUS read sees the same value, as no write shares its cycle
    mode = rbt_mode(st_d.ctrl);

    // Sticky load flags: write one clears, a load in the same cycle wins
    if (reg_wr && rbt_hit(reg_addr, `RBT_OFS_STATUS)) begin
      if (reg_wdata[`RBT_BIT_A]) begin
        st_d.new_a = 1'b0;
      end
      if (reg_wdata[`RBT_BIT_B]) begin
        st_d.new_b = 1'b0;
      end
    end
    if (cap_a) begin
      st_d.new_a = 1'b1;
      st_d.cnt_a = st_q.cnt_a + `RBT_CNT_ONE;
    end
    if (cap_b) begin
      st_d.new_b = 1'b1;
      st_d.cnt_b = st_q.cnt_b + `RBT_CNT_ONE;
    end

    // Read data stand for the one cycle after the read strobe only
    st_d.rdata = `RBT_RD_ZERO;
    if (reg_rd) begin
      case (1'b1)
        rbt_hit(reg_addr, `RBT_OFS_CTRL): begin
          st_d.rdata = {28'h0000000, st_q.ctrl};
        end
        rbt_hit(reg_addr, `RBT_OFS_STORE): begin
          st_d.rdata = {16'h0000, sif.q[`RBT_BIT_B], sif.q[`RBT_BIT_A]};
        end
        rbt_hit(reg_addr, `RBT_OFS_PORTS): begin
          st_d.rdata = {16'h0000, b_in, a_in};
        end
        rbt_hit(reg_addr, `RBT_OFS_STATUS): begin
          st_d.rdata = {28'h0000000, mode, st_q.new_b, st_q.new_a};
        end
        rbt_hit(reg_addr, `RBT_OFS_COUNT): begin
          st_d.rdata = {st_q.cnt_b, st_q.cnt_a};
        end
        default: begin
          st_d.rdata = `RBT_RD_ZERO;
        end
      endcase
    end

    case (mode)
      rbt_pkg::RBT_DRIVE_B: begin
        // A is an input, B is driven; the B-to-A select is ignored
        st_d.a_oe_n = 1'b1;
        st_d.a_out  = '0;
        st_d.b_oe_n = 1'b0;
        if (st_d.ctrl.a_to_b_source_select) begin
          st_d.b_out = a_next;
        end else begin
          st_d.b_out = a_in;
        end
      end
      rbt_pkg::RBT_DRIVE_A: begin
        // B is an input, A is driven; the A-to-B select is ignored
        st_d.b_oe_n = 1'b1;
        st_d.b_out  = '0;
        st_d.a_oe_n = 1'b0;
        if (st_d.ctrl.b_to_a_source_select) begin
          st_d.a_out = b_next;
        end else begin
          st_d.a_out = b_in;
        end
      end
      default: begin
        // Isolation: both ports are inputs, registers load only on
        // their own capture events
        st_d.a_oe_n = 1'b1;
        st_d.b_oe_n = 1'b1;
        st_d.a_out  = '0;
        st_d.b_out  = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset comes up in isolation so the block never fights a bus
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q        <= '0;
      st_q.ctrl   <= `RBT_CTRL_RST;
      st_q.a_oe_n <= 1'b1;
      st_q.b_oe_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st_q.rdata;
  assign a_out     = st_q.a_out;
  assign a_oe_n    = st_q.a_oe_n;
  assign b_out     = st_q.b_out;
  assign b_oe_n    = st_q.b_oe_n;

endmodule

// *** verification/rbt_bus_partner.sv ***
`timescale 1ns/1ps

module rbt_bus_partner (
  input wire logic       a_oe_n,
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_drv,
  input wire logic       b_oe_n,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_drv,
  output logic     [7:0] a_in,
  output logic     [7:0] b_in
);
  // Outside logic lets go of whichever bus the block drives
  assign a_in = a_oe_n ? a_drv : a_out;
  assign b_in = b_oe_n ? b_drv : b_out;
endmodule

// *** verification/rbt_top_sva.sv ***
`timescale 1ns/1ps
`include "rbt_consts.svh"

module rbt_top_sva (
  input wire logic                   core_clk,
  input wire logic                   reset_n,
  input wire logic [`RBT_AW-1:0]     reg_addr,
  input wire logic [`RBT_BUS_DW-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [`RBT_BUS_DW-1:0] reg_rdata,
  input wire logic                   a_side_capture_clock,
  input wire logic                   b_side_capture_clock,
  input wire logic [`RBT_DW-1:0]     a_in,
  input wire logic [`RBT_DW-1:0]     a_out,
  input wire logic                   a_oe_n,
  input wire logic [`RBT_DW-1:0]     b_in,
  input wire logic [`RBT_DW-1:0]     b_out,
  input wire logic                   b_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_ctrl_wr;
    reg_wr && reg_addr == 8'h00;
  endsequence
  sequence s_rd_done;
    reg_rd ##1 !reg_rd;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_iso_write: assert property (s_ctrl_wr ##0 reg_wdata[0] |=>
    a_oe_n && b_oe_n && a_out == 8'h00 && b_out == 8'h00) else $error("isolation missed");
  a_drive_b_on: assert property (s_ctrl_wr ##0 reg_wdata[1:0] == 2'b10 |=>
    !b_oe_n && a_oe_n && a_out == 8'h00) else $error("B not driven");
  a_drive_a_on: assert property (s_ctrl_wr ##0 reg_wdata[1:0] == 2'b00 |=>
    !a_oe_n && b_oe_n && b_out == 8'h00) else $error("A not driven");
  a_live_a_b: assert property (s_ctrl_wr ##0 reg_wdata[2:0] == 3'b010 |=>
    b_out == $past(a_in)) else $error("live A to B wrong");
  a_live_b_a: assert property (s_ctrl_wr ##0 {reg_wdata[3], reg_wdata[1:0]} == 3'b000
    |=> a_out == $past(b_in)) else $error("live B to A wrong");
  a_one_driver: assert property (a_oe_n || b_oe_n)
    else $error("both buses driven");
  a_ports_read: assert property (reg_rd && reg_addr == 8'h0C |=>
    reg_rdata == {16'h0000, $past(b_in), $past(a_in)}) else $error("port read wrong");
  a_read_ends: assert property (s_rd_done |=> reg_rdata == 32'h0000_0000)
    else $error("read data held too long");
endmodule

bind rbt_top rbt_top_sva u_sva (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .a_side_capture_clock, .b_side_capture_clock, .a_in, .a_out,
  .a_oe_n, .b_in, .b_out, .b_oe_n);

// *** verification/registered_bus_transceiver_bench.sv ***
`timescale 1ns/1ps
`include "rbt_consts.svh"

module registered_bus_transceiver_bench;
  logic        core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic        a_side_capture_clock = 0, b_side_capture_clock = 0;
  logic [7:0]  reg_addr = 8'h00, a_drv = 8'h00, b_drv = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'hCC7DEE70;
  logic [7:0]  a_out, b_out, a_in, b_in, a_st, b_st, aw, bw;
  logic        a_oe_n, b_oe_n;
  logic [3:0]  ctrl;
  logic [15:0] ca, cb;
  logic [17:0] e;
  logic [3:0]  corner [4] = '{4'h2, 4'h6, 4'h0, 4'h8};
  int          mismatches = 0, n_checks = 0, cycles = 0;

  rbt_top DUT (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .a_side_capture_clock, .b_side_capture_clock, .a_in, .a_out, .a_oe_n, .b_in, .b_out,
    .b_oe_n);
  rbt_bus_partner u_bus (.a_oe_n, .a_out, .a_drv, .b_oe_n, .b_out, .b_drv, .a_in, .b_in);

  always #2.5 core_clk = ~core_clk;
  // Whole run needs about 2000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      complete_run();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // {a_oe_n, a_out, b_oe_n, b_out}; undriven side reads 0
  function logic [17:0] exp_ports(input logic [3:0] c, input logic [7:0] ad, bd, as, bs);
    if (c[0]) return {1'b1, 8'h00, 1'b1, 8'h00};
    if (c[1]) return {1'b1, 8'h00, 1'b0, c[2] ? as : ad};
    return {1'b0, c[3] ? bs : bd, 1'b1, 8'h00};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task pchk;
    e = exp_ports(ctrl, a_drv, b_drv, a_st, b_st);
    #1 chk({14'h0, a_oe_n, a_out, b_oe_n, b_out}, {14'h0, e});
  endtask
  task do_reset;
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    {a_st, b_st, ca, cb, ctrl} = {8'h00, 8'h00, 16'h0, 16'h0, 4'h1};
    @(posedge core_clk);
    pchk();
    rd(8'h00, 32'h1);
    rd(8'h08, 32'h0);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    rd(8'h20, 32'h0);
    wr(8'h08, 32'hFFFF);
    rd(8'h08, 32'h0);
    for (int i = 0; i < 200; i++) begin
      seed = xs(seed);
      ctrl = (i < 4) ? corner[i] : seed[3:0];
      @(posedge core_clk);
      a_drv <= seed[15:8];
      b_drv <= seed[23:16];
      wr(8'h00, {28'h0, ctrl});
      repeat (2) @(posedge core_clk);
      pchk();
      aw = (!ctrl[0] && !ctrl[1]) ? e[16:9] : a_drv;
      bw = (!ctrl[0] && ctrl[1]) ? e[7:0] : b_drv;
      seed = xs(seed);
      @(posedge core_clk);
      a_side_capture_clock <= seed[0];
      b_side_capture_clock <= seed[1];
      // Capture lands on this edge in every mode
      @(posedge core_clk);
      a_side_capture_clock <= 1'b0;
      b_side_capture_clock <= 1'b0;
      if (seed[0]) {a_st, ca} = {aw, ca + 16'h1};
      if (seed[1]) {b_st, cb} = {bw, cb + 16'h1};
      @(posedge core_clk);
      pchk();
      rd(8'h08, {16'h0, b_st, a_st});
    end
    // Software capture, sticky flags and mode field, from isolation
    wr(8'h00, 32'h1);
    wr(8'h10, 32'h3);
    rd(8'h10, 32'h0);
    wr(8'h04, 32'h3);
    {a_st, b_st, ca, cb} = {a_drv, b_drv, ca + 16'h1, cb + 16'h1};
    rd(8'h08, {16'h0, b_st, a_st});
    rd(8'h0C, {16'h0, b_drv, a_drv});
    rd(8'h10, 32'h3);
    // Clear of new_a meets an A pin edge: the load must win
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= 8'h10;
    reg_wdata <= 32'h1;
    a_side_capture_clock <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    a_side_capture_clock <= 1'b0;
    ca = ca + 16'h1;
    rd(8'h10, 32'h3);
    wr(8'h10, 32'h1);
    rd(8'h10, 32'h2);
    wr(8'h00, 32'h2);
    rd(8'h10, 32'h6);
    wr(8'h00, 32'h0);
    rd(8'h10, 32'hA);
    rd(8'h14, {cb, ca});
    do_reset();
    complete_run();
  end
endmodule
